// *** srg_pkg.sv ***
package srg_pkg;

    // ------------------------------------------------------------------
    // Timebase and timing constants
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS     = 8000;
    localparam longint unsigned DELAY_SHORT_US = 2190;
    localparam longint unsigned DELAY_MID_US   = 35000;
    localparam longint unsigned DELAY_LONG_US  = 280000;
    // Release delays are longest-style figures: round down, at least one.
    localparam longint unsigned DELAY_SHORT_CYC = (DELAY_SHORT_US * 64'd1000000) / CLK_PERIOD_PS;
    localparam longint unsigned DELAY_MID_CYC   = (DELAY_MID_US * 64'd1000000) / CLK_PERIOD_PS;
    localparam longint unsigned DELAY_LONG_CYC  = (DELAY_LONG_US * 64'd1000000) / CLK_PERIOD_PS;
    // Glitch rejection is a least time: round up.
    localparam int unsigned GLITCH_NS  = 100;
    localparam int unsigned GLITCH_CYC = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // Build options
    // ------------------------------------------------------------------
    localparam logic [1:0] DELAY_SEL_SHORT = 2'h0;
    localparam logic [1:0] DELAY_SEL_MID   = 2'h1;
    localparam logic [1:0] DELAY_SEL_LONG  = 2'h2;
    localparam int unsigned RELEASE_CNT_W  = 26;
    localparam int unsigned FILT_CNT_W     = 8;

    typedef enum logic [1:0] {
        SRG_HOLD,
        SRG_TIMING,
        SRG_RELEASED
    } srg_state_t;

endpackage : srg_pkg

// *** srg_mr_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface srg_mr_if;
    logic mrActive;
    modport filt (output mrActive);
    modport gen  (input  mrActive);
endinterface : srg_mr_if
`default_nettype wire

// *** srg_mr_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
module srg_mr_filter
    import srg_pkg::*;
#(
    parameter int unsigned STABLE_CYC = GLITCH_CYC
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic manualResetRequest_n,
    srg_mr_if.filt    mrOut
);

    // ------------------------------------------------------------------
    // Two-stage synchroniser, then a stability counter
    // ------------------------------------------------------------------
    logic                  sync1_ff;
    logic                  sync2_ff;
    logic                  level_ff;
    logic [FILT_CNT_W-1:0] cnt_ff;
    logic                  nxt_level;
    logic [FILT_CNT_W-1:0] nxt_cnt;

    // Sync flops reset high so a pin left at its pulled-up level reads idle.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end else begin
            sync1_ff <= manualResetRequest_n;
            sync2_ff <= sync1_ff;
        end
    end

    // A new level is accepted only after it holds for STABLE_CYC cycles, so short lows die here.
    always_comb begin
        nxt_level = level_ff;
        nxt_cnt   = '0;
        if (sync2_ff != level_ff) begin
            if (cnt_ff == FILT_CNT_W'(STABLE_CYC - 1)) begin
                nxt_level = sync2_ff;
            end else begin
                nxt_cnt = cnt_ff + FILT_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            level_ff <= 1'b1;
            cnt_ff   <= '0;
        end else begin
            level_ff <= nxt_level;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign mrOut.mrActive = ~level_ff;

    chk_glitch_reject : assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(level_ff) |-> $past(sync2_ff, 1) == 1'b0)
        else $error("filter fell on high input");

endmodule : srg_mr_filter
`default_nettype wire

// *** srg_reset_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
module srg_reset_gen
    import srg_pkg::*;
#(
    parameter logic [1:0]  DELAY_SEL   = DELAY_SEL_LONG,
    parameter bit          ACTIVE_HIGH = 1'b0,
    parameter bit          OPEN_DRAIN  = 1'b0,
    parameter int unsigned MR_STABLE_CYC = GLITCH_CYC,
    parameter longint unsigned RELEASE_CYC = (DELAY_SEL == DELAY_SEL_SHORT) ? DELAY_SHORT_CYC :
                                             (DELAY_SEL == DELAY_SEL_MID)   ? DELAY_MID_CYC   :
                                                                              DELAY_LONG_CYC
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic supplyLow,
    input  wire logic manualResetRequest_n,
    output logic      systemResetOut,
    output logic      systemResetOe,
    output logic      resetActive
);

    // ------------------------------------------------------------------
    // Manual request filter
    // ------------------------------------------------------------------
    // The filter sees the raw pin level; the pull-up that keeps it idle sits outside this logic.
    srg_mr_if mrLink ();

    // Only the stability count is set here; the synchroniser depth is fixed at two flops.
    srg_mr_filter #(
        .STABLE_CYC (MR_STABLE_CYC)
    ) uFilter (
        .mclk                 (mclk),
        .reset_n              (reset_n),
        .manualResetRequest_n (manualResetRequest_n),
        .mrOut                (mrLink.filt)
    );

    // ------------------------------------------------------------------
    // Release sequencer
    // ------------------------------------------------------------------
    // The count starts at zero, so the terminal value sits one below the cycle count.
    // A count too big for the counter width would wrap; widen the package width before choosing one.
    localparam logic [RELEASE_CNT_W-1:0] TERM_CNT = RELEASE_CNT_W'(RELEASE_CYC - 1);

    // Sequencer state, release counter and the registered reset level.
    srg_state_t               state_ff;
    srg_state_t               nxt_state;
    logic [RELEASE_CNT_W-1:0] cnt_ff;
    logic [RELEASE_CNT_W-1:0] nxt_cnt;
    logic                     active_ff;
    logic                     nxt_active;
    logic                     request;

    // ------------------------------------------------------------------
    // Reset request
    // ------------------------------------------------------------------
    // Either source alone is enough to demand reset.
    assign request = supplyLow | mrLink.mrActive;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // The output has its own register, set alongside the state; the request bypasses the timer so assertion is immediate.
    // Every path defaults to active, so an unexpected state fails safe with the system held.
    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_active = 1'b1;
        case (state_ff)
            SRG_HOLD: begin
                nxt_cnt = '0;
                if (!request) begin
                    nxt_state = SRG_TIMING;
                end
            end
            SRG_TIMING: begin
                if (request) begin
                    nxt_state = SRG_HOLD;
                    nxt_cnt   = '0;
                end else if (cnt_ff == TERM_CNT) begin
                    nxt_state  = SRG_RELEASED;
                    nxt_active = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff + RELEASE_CNT_W'(1);
                end
            end
            SRG_RELEASED: begin
                nxt_active = 1'b0;
                if (request) begin
                    nxt_state  = SRG_HOLD;
                    nxt_active = 1'b1;
                    nxt_cnt    = '0;
                end
            end
            default: begin
                nxt_state = SRG_HOLD;
                nxt_cnt   = '0;
            end
        endcase
        if (request) begin
            nxt_active = 1'b1;
        end
    end

    // Reset leaves the system held in reset, the safe state at power up.
    // The counter clears too, so a stale count can never shorten the first delay.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff  <= SRG_HOLD;
            cnt_ff    <= '0;
            active_ff <= 1'b1;
        end else begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            active_ff <= nxt_active;
        end
    end

    // ------------------------------------------------------------------
    // Output driver
    // ------------------------------------------------------------------
    // The internal level goes out as is, so a user never has to undo the pin polarity.
    // Polarity and drive style are constants, so the unused option folds away for free.
    // Open drain only ever pulls low, so it is forced active low regardless of polarity.
    assign resetActive    = active_ff;
    assign systemResetOut = OPEN_DRAIN ? 1'b0 : (ACTIVE_HIGH ? active_ff : ~active_ff);
    assign systemResetOe  = OPEN_DRAIN ? active_ff : 1'b1;

    // ------------------------------------------------------------------
    // Checks on the sequencer and the output driver
    // ------------------------------------------------------------------
    // These checks watch the state and output registers and sleep while in reset.
    // A low supply always leaves the output active one edge later.
    chk_supply_hold : assert property (@(posedge mclk) disable iff (!reset_n)
        supplyLow |=> resetActive)
        else $error("reset not held while supply low");

    // A request seen while released must assert within a single edge.
    chk_fast_assert : assert property (@(posedge mclk) disable iff (!reset_n)
        (!resetActive && request) |=> resetActive)
        else $error("reset assertion delayed");

    // Release only ever follows the last timing cycle.
    chk_no_early_rel : assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(resetActive) |-> $past(state_ff, 1) == SRG_TIMING && $past(cnt_ff, 1) == TERM_CNT)
        else $error("release before timer expiry");

    // While timing, the output must never have dropped early.
    chk_timer_hold : assert property (@(posedge mclk) disable iff (!reset_n)
        state_ff == SRG_TIMING |-> resetActive)
        else $error("output inactive while timing");

    // A request in mid-timing throws the count away.
    chk_timer_clear : assert property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == SRG_TIMING && request) |=> state_ff == SRG_HOLD && cnt_ff == '0)
        else $error("timer not cleared by request");

    // Holding ends only when both sources are quiet.
    chk_start_both : assert property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == SRG_HOLD && request) |=> state_ff == SRG_HOLD)
        else $error("timer started early");

    // The first quiet edge starts the timer from zero.
    chk_start_zero : assert property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == SRG_HOLD && !request) |=> state_ff == SRG_TIMING && cnt_ff == '0)
        else $error("timer not started from zero");

    // Holding keeps the counter at zero so a later release times the full delay.
    chk_hold_zero : assert property (@(posedge mclk) disable iff (!reset_n)
        state_ff == SRG_HOLD |-> cnt_ff == '0)
        else $error("counter not cleared while holding");

    // Each quiet timing edge below the terminal count moves the counter by exactly one.
    chk_count_step : assert property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == SRG_TIMING && !request && cnt_ff != TERM_CNT) |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("release counter did not advance");

    // Once released, the output stays inactive until a new request.
    chk_rel_stay : assert property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == SRG_RELEASED && !request) |=> state_ff == SRG_RELEASED && !resetActive)
        else $error("output reasserted with no request");

    // An accepted manual request reaches the output one edge later.
    chk_manual_act : assert property (@(posedge mclk) disable iff (!reset_n)
        mrLink.mrActive |=> resetActive)
        else $error("manual request ignored");

    // Push-pull builds drive the pin at the chosen polarity.
    chk_out_polar : assert property (@(posedge mclk) disable iff (!reset_n)
        !OPEN_DRAIN |-> systemResetOut == (ACTIVE_HIGH ? resetActive : !resetActive))
        else $error("output polarity wrong");

    // Push-pull builds drive the pin in both states.
    chk_pp_drive : assert property (@(posedge mclk) disable iff (!reset_n)
        !OPEN_DRAIN |-> systemResetOe)
        else $error("push pull output not driven");

    // Open drain pulls low only while active and floats once released.
    chk_od_release : assert property (@(posedge mclk) disable iff (!reset_n)
        OPEN_DRAIN |-> systemResetOe == resetActive && systemResetOut == 1'b0)
        else $error("open drain drives inactive");

endmodule : srg_reset_gen
`default_nettype wire

// *** srg_mcu_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module srg_mcu_model #(
    parameter bit ACTIVE_HIGH = 1'b0
) (
    input  wire logic resetPinOut,
    input  wire logic resetPinOe,
    output logic      heldInReset
);
    logic pinLevel;
    // A released pin floats up to the board pull-up, so the processor never sees a stale level.
    assign pinLevel = resetPinOe ? resetPinOut : 1'b1;
    // The processor decodes the pin with the polarity of the build option.
    assign heldInReset = ACTIVE_HIGH ? pinLevel : ~pinLevel;
endmodule : srg_mcu_model
`default_nettype wire

// *** supervisor_reset_generator_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module supervisor_reset_generator_bench;
    import srg_pkg::*;
    localparam int REL = 20;
    localparam int MRS = 4;
    logic mclk        = 1'b0;
    logic reset_n     = 1'b0;
    logic supplyLow   = 1'b1;
    logic mrN         = 1'b1;
    logic pinOut;
    logic pinOe;
    logic resetActive;
    logic heldInReset;
    logic hiOut;
    logic hiOe;
    logic hiHeld;
    logic odOut;
    logic odOe;
    logic odHeld;
    int   failures    = 0;
    int   cmp_count   = 0;
    int   seed        = 32'h1306bf8c;
    int   k;

    // The clock toggles every half period.
    always #4 mclk = ~mclk;

    srg_reset_gen #(.DELAY_SEL(DELAY_SEL_SHORT), .MR_STABLE_CYC(MRS), .RELEASE_CYC(REL)) dut_u (
        .mclk(mclk), .reset_n(reset_n), .supplyLow(supplyLow), .manualResetRequest_n(mrN),
        .systemResetOut(pinOut), .systemResetOe(pinOe), .resetActive(resetActive));
    srg_mcu_model #(.ACTIVE_HIGH(1'b0)) mcu_u (
        .resetPinOut(pinOut), .resetPinOe(pinOe), .heldInReset(heldInReset));
    // Two more builds share the stimulus so the other output options are exercised too.
    srg_reset_gen #(.DELAY_SEL(DELAY_SEL_SHORT), .ACTIVE_HIGH(1'b1), .MR_STABLE_CYC(MRS),
                    .RELEASE_CYC(REL)) dutHi_u (
        .mclk(mclk), .reset_n(reset_n), .supplyLow(supplyLow), .manualResetRequest_n(mrN),
        .systemResetOut(hiOut), .systemResetOe(hiOe), .resetActive());
    srg_mcu_model #(.ACTIVE_HIGH(1'b1)) mcuHi_u (
        .resetPinOut(hiOut), .resetPinOe(hiOe), .heldInReset(hiHeld));
    srg_reset_gen #(.DELAY_SEL(DELAY_SEL_SHORT), .OPEN_DRAIN(1'b1), .MR_STABLE_CYC(MRS),
                    .RELEASE_CYC(REL)) dutOd_u (
        .mclk(mclk), .reset_n(reset_n), .supplyLow(supplyLow), .manualResetRequest_n(mrN),
        .systemResetOut(odOut), .systemResetOe(odOe), .resetActive());
    srg_mcu_model #(.ACTIVE_HIGH(1'b0)) mcuOd_u (
        .resetPinOut(odOut), .resetPinOe(odOe), .heldInReset(odHeld));

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check

    // Counts edges until the output releases; bounded so a stuck output cannot hang the run.
    task automatic release_edges(output int n);
        n = 0;
        while (resetActive !== 1'b0) begin
            @(posedge mclk);
            n++;
            #1;
            if (n > 400) begin
                failures++;
                stop_test();
            end
        end
    endtask : release_edges

    // The first edge without a request starts the timer, so the release lands one edge late.
    function automatic int exp_release();
        return REL + 1;
    endfunction : exp_release

    // A released manual input first crosses two sync flops and the stability count, then times the delay.
    function automatic int exp_manual_release();
        return 2 + MRS + exp_release();
    endfunction : exp_manual_release

    // Main sequence.
    initial begin
        repeat (11) @(posedge mclk);
        @(negedge mclk);
        check("active in reset", resetActive, 1'b1);
        @(posedge mclk);
        reset_n <= 1'b1;
        repeat (5) @(posedge mclk);
        #1 check("held while supply low", resetActive, 1'b1);
        @(posedge mclk);
        supplyLow <= 1'b0;
        release_edges(k);
        check("release count", k, exp_release());
        check("pin released", heldInReset, 1'b0);
        check("high pin released", hiHeld, 1'b0);
        check("open drain floats", odOe, 1'b0);
        check("open drain pin released", odHeld, 1'b0);
        @(posedge mclk);
        supplyLow <= 1'b1;
        @(posedge mclk);
        #1 check("fast assert", resetActive, 1'b1);
        check("pin active", heldInReset, 1'b1);
        check("high pin active", hiHeld, 1'b1);
        check("open drain pulls", odOe, 1'b1);
        check("open drain level", odOut, 1'b0);
        check("open drain pin active", odHeld, 1'b1);
        // A request in mid-timing must restart the whole delay.
        repeat (4) begin
            k = 2 + ($unsigned($random(seed)) % (REL - 4));
            @(posedge mclk);
            supplyLow <= 1'b0;
            repeat (k) @(posedge mclk);
            supplyLow <= 1'b1;
            @(posedge mclk);
            #1 check("restart hold", resetActive, 1'b1);
            @(posedge mclk);
            supplyLow <= 1'b0;
            release_edges(k);
            check("restart count", k, exp_release());
        end
        // Short manual lows must never reach the output.
        repeat (8) begin
            k = 1 + ($unsigned($random(seed)) % 3);
            @(posedge mclk);
            mrN <= 1'b0;
            repeat (k) @(posedge mclk);
            mrN <= 1'b1;
            repeat (10) begin
                @(posedge mclk);
                #1 check("glitch ignored", resetActive, 1'b0);
            end
        end
        // A held manual request asserts after the filter and overlaps a supply dip.
        @(posedge mclk);
        mrN <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 check("no early manual", resetActive, 1'b0);
        repeat (7) @(posedge mclk);
        #1 check("manual assert", resetActive, 1'b1);
        @(posedge mclk);
        supplyLow <= 1'b1;
        repeat (3) @(posedge mclk);
        supplyLow <= 1'b0;
        repeat (REL + 5) @(posedge mclk);
        #1 check("manual still holds", resetActive, 1'b1);
        @(posedge mclk);
        mrN <= 1'b1;
        release_edges(k);
        check("manual full delay", k, exp_manual_release());
        stop_test();
    end
endmodule : supervisor_reset_generator_bench
`default_nettype wire
